// *** inc/gtimer_pkg.sv ***
// Shared constants, register map and types of the general timer slice
`default_nettype none
package gtimer_pkg;
  // Register bus geometry: word index, byte address is index * 4
  localparam int IDX_W = 4;
  localparam int ADDR_W = 6;
  localparam int BANK_WORDS = 16;
  localparam int CNT_W = 16;
  typedef logic [IDX_W-1:0] reg_idx_t;

  // Word indices of the register map
  localparam reg_idx_t IDX_CTL0 = 4'h0;
  localparam reg_idx_t IDX_CHCTL = 4'h1;
  localparam reg_idx_t IDX_SWEVG = 4'h2;
  localparam reg_idx_t IDX_CNT = 4'h3;
  localparam reg_idx_t IDX_PSC = 4'h4;
  localparam reg_idx_t IDX_CAR = 4'h5;
  localparam reg_idx_t IDX_CV0 = 4'h6;
  localparam reg_idx_t IDX_CV3 = 4'h9;
  localparam reg_idx_t IDX_DMACFG = 4'ha;
  localparam reg_idx_t IDX_DMATB = 4'hb;
  localparam reg_idx_t IDX_MISC = 4'hc;
  localparam reg_idx_t IDX_STAT = 4'hd;

  // timer_control_0 field positions and reset value
  localparam int CTL0_RUN = 0;
  localparam int CTL0_UPDATE_DISABLE = 1;
  localparam int CTL0_UPS = 2;
  localparam int CTL0_SPM = 3;
  localparam int CTL0_DIR = 4;
  localparam int CTL0_ALIGN = 5;
  localparam int CTL0_AUTORELOAD_SHADOW_EN = 7;
  localparam int CTL0_CLOCK_DIVIDE = 8;
  localparam logic [31:0] CTL0_RESET = 32'h0000_0000;

  // Channel control: mode at 3*ch, clear enable at CHCTL_CLR + ch
  localparam int CHCTL_CLR = 12;
  // Software event register
  localparam int SWEVG_UG = 0;
  // DMA config: address field at [4:0], count field at [12:8]
  localparam int DMACFG_CNT = 8;
  // Misc: trigger select [2:0], debug hold, update DMA enable
  localparam int MISC_HOLD = 4;
  localparam int MISC_UDE = 5;
  // Status: flags [3:0] (write one to clear), prepare [7:4], then levels
  localparam int STAT_PREP = 4;
  localparam int STAT_ETF = 8;
  localparam int STAT_ITI = 9;
  localparam int STAT_DMA = 10;

  typedef enum logic [2:0] {
    CMP_KEEP       = 3'b000,
    CMP_SET_HIGH   = 3'b001,
    CMP_TOGGLE     = 3'b010,
    CMP_SET_LOW    = 3'b011,
    CMP_FORCE_LOW  = 3'b100,
    CMP_FORCE_HIGH = 3'b101,
    CMP_PWM0       = 3'b110,
    CMP_PWM1       = 3'b111
  } cmp_mode_t;

  typedef enum logic [1:0] {
    ALIGN_EDGE  = 2'b00,
    ALIGN_CDOWN = 2'b01,
    ALIGN_CUP   = 2'b10,
    ALIGN_CBOTH = 2'b11
  } align_t;

  typedef enum logic [1:0] {
    CLOCK_DIVIDE_1   = 2'b00,
    CLOCK_DIVIDE_2   = 2'b01,
    CLOCK_DIVIDE_4   = 2'b10,
    CLOCK_DIVIDE_RSV = 2'b11
  } clock_divide_t;

  typedef enum logic {
    DMA_IDLE = 1'b0,
    DMA_BUSY = 1'b1
  } dma_state_t;
endpackage
`default_nettype wire

// *** inc/regbank_if.sv ***
// Interface between timer control logic and its register bank
`default_nettype none
interface regbank_if;
  import gtimer_pkg::*;
  logic wr_en;
  logic rd_en;
  reg_idx_t idx;
  logic [31:0] wr_data;
  logic top_sel;
  logic [31:0] top_val;
  logic [31:0] rd_data;
  logic [31:0] words [BANK_WORDS];
  modport ctrl (
    output wr_en, rd_en, idx, wr_data, top_sel, top_val,
    input rd_data, words
  );
  modport bank (
    input wr_en, rd_en, idx, wr_data, top_sel, top_val,
    output rd_data, words
  );
endinterface
`default_nettype wire

// *** verilog/timer_regbank.sv ***
// Plain software register bank with registered read data
`default_nettype none
module timer_regbank
  import gtimer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Control side
  regbank_if.bank rb
);
  // Storage; hardware-owned words are supplied through top_val
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < BANK_WORDS; i++) begin
        rb.words[i] <= 32'h0000_0000;
      end
    end else if (rb.wr_en) begin
      rb.words[rb.idx] <= rb.wr_data;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rb.rd_data <= 32'h0000_0000;
    end else if (rb.rd_en) begin
      rb.rd_data <= rb.top_sel ? rb.top_val : rb.words[rb.idx];
    end else begin
      rb.rd_data <= 32'h0000_0000;
    end
  end
endmodule // timer_regbank
`default_nettype wire

// *** verilog/general_timer_compare_ctrl.sv ***
// General timer slice: counter, compare outputs, triggers, DMA window
// Notes on behaviour
// - Keep-level code leaves output prepare unchanged on a compare match.
// - Set-high code drives output prepare high on a compare match.
// - Set-low code drives output prepare low on a compare match.
// - PWM codes derive output prepare from direction and counter comparison.
// - Force codes hold output prepare inactive or active, ignoring compares.
// - Clear enable with filtered external trigger high forces prepare to 0.
// - After a trigger clear, prepare stays inactive until the next update.
// - Trigger select picks one of three peer sources; codes 3 to 7 select none.
// - Buffer register accesses are redirected to the DMA-addressed register.
// - Each DMA event issues count plus one requests, stepping one word each.
// - Debug halt with hold bit set stops the counter.
// - Clock division sets filter sample rate to clock over 1, 2 or 4.
// - Shadow enable buffers the auto-reload value; otherwise bypassed.
// - Alignment selects edge counting or which directions may set flags.
// - Direction bit: 0 up, 1 down; read-only in center alignment.
// - Single pulse stops the counter at the next update event.
// - Update source 1 restricts DMA update requests to overflow/underflow.
// - Each enabled update event loads shadows from preloaded values.
// - Update disable blocks updates; software generate still reinitializes.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module general_timer_compare_ctrl
  import gtimer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // Asynchronous inputs
  input wire logic ext_trigger_pin_i,
  input wire logic [2:0] trig_src_i,
  input wire logic debug_halt_i,
  // Outputs
  output logic [3:0] ch_output_prepare_o,
  output logic dma_req_o,
  output logic update_event_o
);
  regbank_if rb ();

  // Software registers held in the bank
  timer_regbank u_bank (
    .ref_clk_i (ref_clk_i),
    .rst_b_i (rst_b_i),
    .rb (rb.bank)
  );

  // Two-flop synchronisers for pins; first stage read only by second
  logic [4:0] sync_1;
  logic [4:0] sync_2;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_1 <= 5'h00;
      sync_2 <= 5'h00;
    end else begin
      sync_1 <= {debug_halt_i, trig_src_i, ext_trigger_pin_i};
      sync_2 <= sync_1;
    end
  end
  wire ext_s = sync_2[0];
  wire [2:0] trig_s = sync_2[3:1];
  wire halt_s = sync_2[4];

  // Control register fields
  logic counter_run, update_disable, update_source_sel, single_pulse;
  logic dir, autoreload_shadow_en;
  align_t align_mode;
  clock_divide_t clock_divide;

  // Hardware state
  logic [CNT_W-1:0] cnt, psc_cnt, psc_shadow, car_shadow;
  logic [3:0] ch_output_prepare, trig_cleared, ch_flag;
  logic [1:0] fdiv;
  logic etf_prev, ext_trigger_filtered;
  logic internal_trigger_in;
  dma_state_t dma_state;
  logic [4:0] dma_idx;

  // Bank words
  wire [31:0] chctl = rb.words[IDX_CHCTL];
  wire [31:0] dma_config = rb.words[IDX_DMACFG];
  wire [31:0] misc = rb.words[IDX_MISC];
  wire [CNT_W-1:0] psc_pre = rb.words[IDX_PSC][CNT_W-1:0];
  wire [CNT_W-1:0] car_pre = rb.words[IDX_CAR][CNT_W-1:0];
  wire [4:0] dma_transfer_addr = dma_config[4:0];
  wire [4:0] dma_transfer_count = dma_config[DMACFG_CNT+:5];
  wire [2:0] trigger_select = misc[2:0];
  wire debug_hold = misc[MISC_HOLD];

  function automatic logic is_bank(input reg_idx_t i);
    return (i == IDX_CHCTL) || (i == IDX_PSC) || (i == IDX_CAR) ||
           ((i >= IDX_CV0) && (i <= IDX_CV3)) || (i == IDX_DMACFG) ||
           (i == IDX_MISC);
  endfunction

  // Next prepare level for one channel from its compare mode
  function automatic logic next_prep(input cmp_mode_t m, input logic cur,
                                     input logic match, input logic lt,
                                     input logic le, input logic down);
    logic pwm_act;
    pwm_act = down ? le : lt;
    unique case (m)
      CMP_KEEP: return cur;
      CMP_SET_HIGH: return match ? 1'b1 : cur;
      CMP_TOGGLE: return match ? ~cur : cur;
      CMP_SET_LOW: return match ? 1'b0 : cur;
      CMP_FORCE_LOW: return 1'b0;
      CMP_FORCE_HIGH: return 1'b1;
      CMP_PWM0: return pwm_act;
      CMP_PWM1: return ~pwm_act;
    endcase
  endfunction

  // Address decode; buffer window redirects to the DMA-addressed word
  wire buf_hit = (addr_i[ADDR_W-1:2] == IDX_DMATB);
  wire reg_idx_t dma_eff = reg_idx_t'(dma_transfer_addr[3:0] +
                                      dma_idx[3:0]);
  wire reg_idx_t eff_idx = buf_hit ? dma_eff : addr_i[ADDR_W-1:2];
  wire eff_ok = (eff_idx != IDX_DMATB) && (eff_idx <= IDX_STAT);
  wire wr = wr_i & eff_ok;
  wire buf_access = buf_hit & (wr_i | rd_i);
  wire wr_ctl0 = wr & (eff_idx == IDX_CTL0);
  wire wr_cnt = wr & (eff_idx == IDX_CNT);
  wire wr_stat = wr & (eff_idx == IDX_STAT);
  wire sw_update = wr & (eff_idx == IDX_SWEVG) & wr_data_i[SWEVG_UG];

  // Read values of hardware-owned words
  wire [31:0] ctl0_word = {22'h0, clock_divide, autoreload_shadow_en,
                           align_mode, dir, single_pulse, update_source_sel,
                           update_disable, counter_run};
  wire [31:0] stat_word = {21'h0, dma_state == DMA_BUSY,
                           internal_trigger_in, ext_trigger_filtered,
                           ch_output_prepare, ch_flag};
  assign rb.wr_en = wr & is_bank(eff_idx);
  assign rb.rd_en = rd_i;
  assign rb.idx = eff_idx;
  assign rb.wr_data = wr_data_i;
  assign rb.top_sel = ~is_bank(eff_idx) | ~eff_ok;
  assign rb.top_val = !eff_ok ? 32'h0000_0000 :
                      (eff_idx == IDX_CTL0) ? ctl0_word :
                      (eff_idx == IDX_CNT) ? {16'h0000, cnt} :
                      (eff_idx == IDX_STAT) ? stat_word : 32'h0000_0000;
  assign rd_data_o = rb.rd_data;

  // Peer trigger routing; code 3 and above select nothing
  assign internal_trigger_in = (trigger_select < 3'h3) ?
                               trig_s[trigger_select[1:0]] : 1'b0;

  // Filter sample enable from the clock divider
  wire filter_sample_clock = (clock_divide == CLOCK_DIVIDE_2) ? fdiv[0] :
                             (clock_divide == CLOCK_DIVIDE_4) ? (fdiv == 2'h3) :
                             1'b1;

  // Counter control terms
  wire halted = halt_s & debug_hold;
  wire center = (align_mode != ALIGN_EDGE);
  wire [CNT_W-1:0] car_eff = autoreload_shadow_en ? car_shadow :
                             car_pre;
  wire tick = counter_run & ~halted & (psc_cnt == psc_shadow);
  wire ovf_udf = tick & (center ?
                 (dir ? (cnt == 16'h0001) : (cnt == car_eff - 1'b1)) :
                 (dir ? (cnt == 16'h0000) : (cnt == car_eff)));
  wire update_evt = (sw_update | ovf_udf) & ~update_disable;
  wire dma_update_evt = update_evt &
                        (update_source_sel ? ovf_udf : 1'b1);

  // Channel compare terms
  logic [3:0] prep_next, flag_set;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic [CNT_W-1:0] cv;
      logic match;
      cv = rb.words[int'(IDX_CV0) + i][CNT_W-1:0];
      match = (cnt == cv);
      prep_next[i] = next_prep(cmp_mode_t'(chctl[3*i+:3]),
                               ch_output_prepare[i], match, cnt < cv,
                               cnt <= cv, dir);
      // Flags only in the directions the alignment allows
      flag_set[i] = match & tick & ((align_mode == ALIGN_EDGE) |
                    (align_mode == ALIGN_CBOTH) |
                    ((align_mode == ALIGN_CDOWN) & dir) |
                    ((align_mode == ALIGN_CUP) & ~dir));
    end
  end
  wire [3:0] clear_now = chctl[CHCTL_CLR+:4] &
                         {4{ext_trigger_filtered}};

  // Divider and two-sample agreement filter on the trigger pin
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fdiv <= 2'h0;
      etf_prev <= 1'b0;
      ext_trigger_filtered <= 1'b0;
    end else begin
      fdiv <= fdiv + 2'h1;
      if (filter_sample_clock) begin
        etf_prev <= ext_s;
        if (etf_prev == ext_s) begin
          ext_trigger_filtered <= ext_s;
        end
      end
    end
  end

  // Control register; direction writable only in edge alignment, toggled by hardware otherwise
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Enum fields need their own casts from the reset word
      clock_divide <= clock_divide_t'(CTL0_RESET[CTL0_CLOCK_DIVIDE+:2]);
      autoreload_shadow_en <= CTL0_RESET[CTL0_AUTORELOAD_SHADOW_EN];
      align_mode <= align_t'(CTL0_RESET[CTL0_ALIGN+:2]);
      dir <= CTL0_RESET[CTL0_DIR];
      single_pulse <= CTL0_RESET[CTL0_SPM];
      update_source_sel <= CTL0_RESET[CTL0_UPS];
      update_disable <= CTL0_RESET[CTL0_UPDATE_DISABLE];
      counter_run <= CTL0_RESET[CTL0_RUN];
    end else begin
      if (wr_ctl0) begin
        clock_divide <= clock_divide_t'(wr_data_i[CTL0_CLOCK_DIVIDE+:2]);
        autoreload_shadow_en <= wr_data_i[CTL0_AUTORELOAD_SHADOW_EN];
        align_mode <= align_t'(wr_data_i[CTL0_ALIGN+:2]);
        single_pulse <= wr_data_i[CTL0_SPM];
        update_source_sel <= wr_data_i[CTL0_UPS];
        update_disable <= wr_data_i[CTL0_UPDATE_DISABLE];
        counter_run <= wr_data_i[CTL0_RUN];
      end else if (update_evt & single_pulse) begin
        counter_run <= 1'b0;
      end
      if (wr_ctl0 & ~center) begin
        dir <= wr_data_i[CTL0_DIR];
      end else if (ovf_udf & center) begin
        dir <= ~dir;
      end
    end
  end

  // Counter, prescaler and shadows
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 16'h0000;
      psc_cnt <= 16'h0000;
      psc_shadow <= 16'h0000;
      car_shadow <= 16'h0000;
    end else begin
      if (update_evt) begin
        psc_shadow <= psc_pre;
        car_shadow <= car_pre;
      end
      if (sw_update) begin
        // Reinit happens even with updates disabled
        psc_cnt <= 16'h0000;
        cnt <= (center | ~dir) ? 16'h0000 : car_eff;
      end else if (wr_cnt) begin
        cnt <= wr_data_i[CNT_W-1:0];
      end else if (counter_run & ~halted) begin
        psc_cnt <= tick ? 16'h0000 : psc_cnt + 1'b1;
        if (tick) begin
          if (!center & ovf_udf) begin
            cnt <= dir ? car_eff : 16'h0000;
          end else begin
            cnt <= dir ? cnt - 1'b1 : cnt + 1'b1;
          end
        end
      end
    end
  end

  // Output prepare, trigger-clear latch and sticky flags
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch_output_prepare <= 4'h0;
      trig_cleared <= 4'h0;
      ch_flag <= 4'h0;
    end else begin
      // Set wins over the update that releases the latch
      trig_cleared <= clear_now |
                      (trig_cleared & {4{~update_evt}});
      ch_output_prepare <= prep_next & ~clear_now &
                           ~(trig_cleared & {4{~update_evt}});
      ch_flag <= flag_set |
                 (ch_flag & ~({4{wr_stat}} & wr_data_i[3:0]));
    end
  end

  // DMA burst sequencer; events while busy are dropped
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_state <= DMA_IDLE;
      dma_idx <= 5'h00;
      dma_req_o <= 1'b0;
    end else begin
      unique case (dma_state)
        DMA_IDLE: begin
          if (dma_update_evt & misc[MISC_UDE]) begin
            dma_state <= DMA_BUSY;
            dma_req_o <= 1'b1;
          end
        end
        DMA_BUSY: begin
          if (buf_access) begin
            dma_req_o <= 1'b0;
            if (dma_idx == dma_transfer_count) begin
              dma_state <= DMA_IDLE;
              dma_idx <= 5'h00;
            end else begin
              dma_idx <= dma_idx + 5'h01;
            end
          end else if (!dma_req_o) begin
            dma_req_o <= 1'b1;
          end
        end
      endcase
    end
  end

  // Registered outputs
  assign ch_output_prepare_o = ch_output_prepare;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      update_event_o <= 1'b0;
    end else begin
      update_event_o <= update_evt;
    end
  end
endmodule // general_timer_compare_ctrl
`default_nettype wire

// *** dv/gtimer_dma_model.sv ***
// DMA controller model answering timer requests through the buffer window
`default_nettype none
module gtimer_dma_model
  import gtimer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Request side
  input wire logic dma_req_i,
  input wire logic en_i,
  input wire logic stall_i,
  // Bus side
  output logic wr_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [31:0] data_o,
  output logic [7:0] count_o
);
  // Always the buffer window, full words only
  assign addr_o = {IDX_DMATB, 2'b00};
  assign data_o = 32'h0000_a000 + 32'(count_o);

  // One write per request; the gap lets the request drop first
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_o <= 1'b0;
      count_o <= 8'h0;
    end else begin
      wr_o <= en_i && dma_req_i && !wr_o && !stall_i;
      if (wr_o) count_o <= count_o + 8'h1;
    end
  end
endmodule // gtimer_dma_model
`default_nettype wire

// *** dv/gtimer_sva.sv ***
// Port-level checker of the general timer slice
`default_nettype none
module gtimer_sva
  import gtimer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  // Pins and outputs
  input wire logic ext_trigger_pin_i,
  input wire logic [2:0] trig_src_i,
  input wire logic debug_halt_i,
  input wire logic [3:0] ch_output_prepare_o,
  input wire logic dma_req_o,
  input wire logic update_event_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [31:0] ctl0;
  logic [31:0] chctl;
  logic [3:0] hi_cnt;
  logic cleared;
  // Decodes of software traffic
  wire [3:0] idx = addr_i[5:2];
  wire sw_upd = wr_i && idx == IDX_SWEVG && wr_data_i[SWEVG_UG];
  wire buf_acc = (wr_i || rd_i) && idx == IDX_DMATB;
  wire [2:0] mode0 = chctl[2:0];
  wire clr0 = chctl[CHCTL_CLR];
  wire trig_hit = clr0 && ctl0[9:8] == 2'b00 && ext_trigger_pin_i;

  // Write shadows; run bit may lag a single-pulse stop, which only narrows
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl0 <= '0;
      chctl <= '0;
    end else begin
      if (wr_i && idx == IDX_CTL0) ctl0 <= wr_data_i;
      if (wr_i && idx == IDX_CHCTL) chctl <= wr_data_i;
    end
  end

  // Trigger run length and the latched clear it implies
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_cnt <= 4'h0;
      cleared <= 1'b0;
    end else begin
      if (!trig_hit) hi_cnt <= 4'h0;
      else if (hi_cnt != 4'h8) hi_cnt <= hi_cnt + 4'h1;
      if (update_event_o) cleared <= 1'b0;
      else if (hi_cnt == 4'h8) cleared <= 1'b1;
    end
  end

  a_dma_drop: assert property (dma_req_o && buf_acc |=> !dma_req_o)
    else $error("dma request held after buffer access");
  a_sw_update: assert property (sw_upd && !ctl0[CTL0_UPDATE_DISABLE]
    |-> ##[1:3] update_event_o)
    else $error("software update gave no update pulse");
  a_update_disable_block: assert property (ctl0[CTL0_UPDATE_DISABLE]
    && $past(ctl0[CTL0_UPDATE_DISABLE], 3) |-> !update_event_o)
    else $error("update pulse while updates disabled");
  a_ups_no_dma: assert property (ctl0[CTL0_UPS] && !ctl0[CTL0_RUN]
    && !dma_req_o && !$past(dma_req_o) |=> !dma_req_o)
    else $error("dma request without overflow source");
  a_clear_forces: assert property (hi_cnt == 4'h8
    |-> !ch_output_prepare_o[0])
    else $error("trigger clear did not force prepare low");
  a_hold_clear: assert property (cleared && clr0 && !update_event_o
    |-> !ch_output_prepare_o[0])
    else $error("prepare resumed before update");
  a_force_high: assert property ((mode0 == CMP_FORCE_HIGH && !clr0
    && !cleared) [*3] |-> ch_output_prepare_o[0])
    else $error("forced active level missing");
  a_force_low: assert property ((mode0 == CMP_FORCE_LOW) [*3]
    |-> !ch_output_prepare_o[0])
    else $error("forced inactive level missing");
endmodule // gtimer_sva

bind general_timer_compare_ctrl gtimer_sva u_sva (.ref_clk_i, .rst_b_i,
  .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .ext_trigger_pin_i,
  .trig_src_i, .debug_halt_i, .ch_output_prepare_o, .dma_req_o,
  .update_event_o);
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench of the general timer slice
`default_nettype none
module testbench
  import gtimer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_b_i, tb_wr, tb_rd, pin, halt, dm_en, stall;
  logic [5:0] tb_addr;
  logic [31:0] tb_data, rd_v, rd_w;
  logic [2:0] trig;
  wire dm_wr, dma_req, upd;
  wire [5:0] dm_addr;
  wire [31:0] dm_data, rd_data;
  wire [7:0] dm_cnt;
  wire [3:0] prep;
  int miscompares, num_checks, cycles, upd_cnt, u0;
  // Rows: mode nibble, expected prepare nibble, compare value byte
  localparam logic [15:0] ROWS [11] = '{16'h1105, 16'h0105, 16'h3005,
    16'h0005, 16'h5109, 16'h3109, 16'h4009, 16'h6109, 16'h7009,
    16'h6003, 16'h7103};

  always #2 ref_clk_i = ~ref_clk_i;

  general_timer_compare_ctrl u_dut (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .addr_i(dm_wr ? dm_addr : tb_addr),
    .wr_data_i(dm_wr ? dm_data : tb_data), .wr_i(tb_wr | dm_wr),
    .rd_i(tb_rd), .rd_data_o(rd_data), .ext_trigger_pin_i(pin),
    .trig_src_i(trig), .debug_halt_i(halt), .ch_output_prepare_o(prep),
    .dma_req_o(dma_req), .update_event_o(upd));
  gtimer_dma_model u_dma (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .dma_req_i(dma_req), .en_i(dm_en), .stall_i(stall), .wr_o(dm_wr),
    .addr_o(dm_addr), .data_o(dm_data), .count_o(dm_cnt));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Single-cycle strobes with an idle cycle after each
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    tb_addr <= a;
    tb_data <= d;
    tb_wr <= 1'b1;
    @(posedge ref_clk_i);
    tb_wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    tb_addr <= a;
    tb_rd <= 1'b1;
    @(posedge ref_clk_i);
    tb_rd <= 1'b0;
    #1 d = rd_data;
    @(posedge ref_clk_i);
  endtask

  // Hang guard and update pulse count
  always @(posedge ref_clk_i) begin
    cycles++;
    if (upd === 1'b1) upd_cnt++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    {rst_b_i, tb_wr, tb_rd, pin, halt, dm_en, stall} = '0;
    tb_addr = '0;
    tb_data = '0;
    trig = '0;
    wait_n(16);
    rst_b_i <= 1'b1;
    wait_n(1);
    rd_reg(6'h00, rd_v);
    check("ctl0 reset", rd_v, CTL0_RESET);
    wr_reg(6'h0c, 32'h5);
    foreach (ROWS[i]) begin
      wr_reg(6'h18, {24'h0, ROWS[i][7:0]});
      wr_reg(6'h04, {29'h0, ROWS[i][14:12]});
      wait_n(3);
      check("prepare", {31'h0, prep[0]}, {31'h0, ROWS[i][8]});
    end
    // Trigger clear holds until a software update
    wr_reg(6'h04, 32'h1005);
    wait_n(4);
    check("forced", {31'h0, prep[0]}, 32'h1);
    pin <= 1'b1;
    wait_n(12);
    check("cleared", {31'h0, prep[0]}, 32'h0);
    pin <= 1'b0;
    wait_n(12);
    check("held", {31'h0, prep[0]}, 32'h0);
    wr_reg(6'h08, 32'h1);
    wait_n(4);
    check("resumed", {31'h0, prep[0]}, 32'h1);
    wr_reg(6'h04, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr_reg(6'h30, 32'(k));
      trig <= 3'b001 << k;
      wait_n(6);
      rd_reg(6'h34, rd_v);
      check("trigger on", {31'h0, rd_v[STAT_ITI]}, 32'h1);
      trig <= ~(3'b001 << k);
      wait_n(6);
      rd_reg(6'h34, rd_v);
      check("trigger off", {31'h0, rd_v[STAT_ITI]}, 32'h0);
    end
    // Alignment changed only while stopped
    wr_reg(6'h00, 32'h20);
    wr_reg(6'h00, 32'h30);
    rd_reg(6'h00, rd_v);
    check("dir locked", rd_v, 32'h20);
    wr_reg(6'h00, 32'h0);
    wr_reg(6'h00, 32'h10);
    rd_reg(6'h00, rd_v);
    check("dir free", rd_v, 32'h10);
    wr_reg(6'h14, 32'hffff);
    wr_reg(6'h30, 32'h10);
    wr_reg(6'h00, 32'h1);
    halt <= 1'b1;
    wait_n(6);
    rd_reg(6'h0c, rd_v);
    wait_n(10);
    rd_reg(6'h0c, rd_w);
    check("frozen", rd_w, rd_v);
    halt <= 1'b0;
    wait_n(4);
    rd_reg(6'h0c, rd_w);
    check("counting", {31'h0, rd_w != rd_v}, 32'h1);
    wr_reg(6'h0c, 32'h0);
    wr_reg(6'h14, 32'h4);
    wr_reg(6'h00, 32'h9);
    wait_n(30);
    rd_reg(6'h00, rd_v);
    check("one pulse", rd_v, 32'h8);
    wr_reg(6'h00, 32'h2);
    wr_reg(6'h0c, 32'h7);
    u0 = upd_cnt;
    wr_reg(6'h08, 32'h1);
    wait_n(6);
    check("no update", 32'(upd_cnt), 32'(u0));
    rd_reg(6'h0c, rd_v);
    check("reinit", rd_v, 32'h0);
    // Register burst of four words into the compare values
    wr_reg(6'h28, 32'h0306);
    wr_reg(6'h30, 32'h20);
    wr_reg(6'h00, 32'h4);
    dm_en <= 1'b1;
    wr_reg(6'h08, 32'h1);
    wait_n(10);
    check("no dma", {31'h0, dma_req}, 32'h0);
    wr_reg(6'h00, 32'h0);
    for (int e = 0; e < 2; e++) begin
      // Hold the partner back so the pending request can be seen
      stall <= 1'b1;
      wr_reg(6'h08, 32'h1);
      wait_n(10);
      check("dma wait", {31'h0, dma_req}, 32'h1);
      stall <= 1'b0;
      wait_n(40);
      for (int k = 0; k < 4; k++) begin
        rd_reg(6'h18 + 6'(4 * k), rd_v);
        check("burst", rd_v, 32'h0000_a000 + 32'(4 * e + k));
      end
    end
    check("bursts", {24'h0, dm_cnt}, 32'h8);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
